// ---- core/pwg_core.v ----
// Functional notes
// - Three generators, two outputs each
// - One 16-bit counter per generator, two modes
// - Count-down: load to zero, reload
// - Up/down: triangle between zero and load
// - Direction low in down mode, toggles otherwise
// - One-cycle zero and load pulses, held high while load is zero
// - Down mode: load pulse follows zero
// - Comparators A and B pulse on equality
// - Up/down matches split by direction
// - Compare above load never matches
// - Down mode uses four events
// - Up/down mode uses six events
// - Matches ignored on zero or load
// - Output one uses A, two uses B
// - Per event action per output
//
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
`include "pwg_defines.vh"

module pwg_core #(
  parameter NGEN = `PWG_NUM_GEN,
  parameter CW = 16
) (
  input wire clk, // 100 MHz system clock
  input wire sys_rst, // Async reset, active high
  input wire hsel, // AHB slave select
  input wire [31:0] haddr, // AHB address
  input wire [1:0] htrans, // AHB transfer type
  input wire hwrite, // AHB write
  input wire [2:0] hsize, // AHB size
  input wire [31:0] hwdata, // AHB write data
  input wire hready, // AHB bus ready
  output wire [31:0] hrdata, // AHB read data
  output wire hreadyout, // AHB slave ready
  output wire hresp, // AHB response, always OKAY
  output wire [NGEN-1:0] firstGenOutput, // First output per generator
  output wire [NGEN-1:0] secondGenOutput // Second output per generator
);

  function [1:0] pick;
    input [11:0] gen;
    input isZero;
    input isLoad;
    input aEv;
    input bEv;
    input dirUp;
    input useA;
    begin
      pick = `PWG_NOP;
      if (isZero) begin
        pick = gen[`PWG_ACT_ZERO];
      end else if (isLoad) begin
        pick = gen[`PWG_ACT_LOAD];
      end else if (useA && aEv) begin
        pick = dirUp ? gen[`PWG_ACT_AUP] : gen[`PWG_ACT_ADN];
      end else if (!useA && bEv) begin
        pick = dirUp ? gen[`PWG_ACT_BUP] : gen[`PWG_ACT_BDN];
      end
    end
  endfunction

  function applyAct;
    input [1:0] act;
    input cur;
    begin
      case (act)
        `PWG_TOG: applyAct = ~cur;
        `PWG_LOW: applyAct = 1'b0;
        `PWG_HIGH: applyAct = 1'b1;
        default: applyAct = cur;
      endcase
    end
  endfunction

  // Generator window test, shared by the write and read paths
  function regHit;
    input [7:0] addr;
    input [7:0] base;
    reg [7:0] rel;
    begin
      rel = addr - base;
      regHit = (rel < `PWG_GEN_STRIDE);
    end
  endfunction

  function [31:0] readReg;
    input [7:0] rel;
    input [1:0] ctrl;
    input [CW-1:0] loadVal;
    input [CW-1:0] cmpA;
    input [CW-1:0] cmpB;
    input [11:0] genA;
    input [11:0] genB;
    input [CW-1:0] count;
    input dirUp;
    input outA;
    input outB;
    begin
      readReg = 32'h00000000;
      case (rel)
        `PWG_OFF_CTRL: readReg[1:0] = ctrl;
        `PWG_OFF_LOAD: readReg[CW-1:0] = loadVal;
        `PWG_OFF_CMPA: readReg[CW-1:0] = cmpA;
        `PWG_OFF_CMPB: readReg[CW-1:0] = cmpB;
        `PWG_OFF_GENA: readReg[11:0] = genA;
        `PWG_OFF_GENB: readReg[11:0] = genB;
        `PWG_OFF_STAT: begin
          readReg[CW-1:0] = count;
          readReg[`PWG_STAT_DIR] = dirUp;
          readReg[`PWG_STAT_OUTA] = outA;
          readReg[`PWG_STAT_OUTB] = outB;
        end
        default: readReg = 32'h00000000;
      endcase
    end
  endfunction

  // Address phase capture; writes land one cycle later in the data phase
  reg wrPend;
  reg [7:0] wrAddr;
  reg [31:0] rdData;
  reg [31:0] next_rdData;
  wire [7:0] rdAddr = haddr[`PWG_ADDR_BYTE];
  wire access = hsel && hready && (htrans == `PWG_HTRANS_NONSEQ || htrans == `PWG_HTRANS_SEQ);

  // Zero wait states, so the slave never stretches a transfer
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdData;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
    end else begin
      wrPend <= access && hwrite;
      wrAddr <= haddr[`PWG_ADDR_BYTE];
    end
  end

  wire [31:0] rdVec [0:NGEN-1];

  genvar g;
  generate
    for (g = 0; g < NGEN; g = g + 1) begin : genInst
      wire [31:0] baseFull = `PWG_GEN_STRIDE * g;
      wire [7:0] base = baseFull[7:0];
      reg [1:0] ctrl;
      reg [CW-1:0] loadVal;
      reg [CW-1:0] cmpA;
      reg [CW-1:0] cmpB;
      reg [11:0] genA;
      reg [11:0] genB;
      reg [CW-1:0] count;
      reg dirUp;
      reg outA;
      reg outB;
      reg [CW-1:0] next_count;
      reg next_dirUp;
      reg next_outA;
      reg next_outB;
      wire selW = wrPend && regHit(wrAddr, base);
      wire [7:0] wrRel = wrAddr - base;
      wire selR = regHit(rdAddr, base);
      wire [7:0] rdRel = rdAddr - base;
      wire en = ctrl[`PWG_CTRL_EN];
      wire upDown = ctrl[`PWG_CTRL_UPDN];
      wire atZero = (count == {CW{1'b0}});
      wire atLoad = (count == loadVal);
      wire loadZero = (loadVal == {CW{1'b0}});
      // A stale up bit from an earlier up/down run must not leak into down mode
      wire dirEff = upDown && dirUp;
      // Pulses are combinational on the count, so each lasts one cycle unless load is zero and the count holds at zero
      wire zeroEv = en && atZero;
      wire loadEv = en && atLoad;
      // Guard keeps a compare above load silent even after load shrinks
      wire aEv = en && (count == cmpA) && (cmpA <= loadVal);
      wire bEv = en && (count == cmpB) && (cmpB <= loadVal);
      wire [1:0] actA = pick(genA, zeroEv, loadEv, aEv, bEv, dirEff, 1'b1);
      wire [1:0] actB = pick(genB, zeroEv, loadEv, aEv, bEv, dirEff, 1'b0);
      wire wrCtrl = selW && (wrRel == `PWG_OFF_CTRL);
      wire wrLoad = selW && (wrRel == `PWG_OFF_LOAD);
      wire wrCmpA = selW && (wrRel == `PWG_OFF_CMPA);
      wire wrCmpB = selW && (wrRel == `PWG_OFF_CMPB);
      wire wrGenA = selW && (wrRel == `PWG_OFF_GENA);
      wire wrGenB = selW && (wrRel == `PWG_OFF_GENB);

      always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          ctrl <= 2'h0;
        end else if (wrCtrl) begin
          ctrl <= hwdata[1:0];
        end
      end

      always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          loadVal <= {CW{1'b0}};
        end else if (wrLoad) begin
          loadVal <= hwdata[CW-1:0];
        end
      end

      always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          cmpA <= {CW{1'b0}};
        end else if (wrCmpA) begin
          cmpA <= hwdata[CW-1:0];
        end
      end

      always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          cmpB <= {CW{1'b0}};
        end else if (wrCmpB) begin
          cmpB <= hwdata[CW-1:0];
        end
      end

      always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          genA <= 12'h000;
        end else if (wrGenA) begin
          genA <= hwdata[11:0];
        end
      end

      always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          genB <= 12'h000;
        end else if (wrGenB) begin
          genB <= hwdata[11:0];
        end
      end

      always @* begin
        next_count = count;
        next_dirUp = dirUp;
        next_outA = applyAct(actA, outA);
        next_outB = applyAct(actB, outB);
        if (!en) begin
          // Disabled generator parks at zero with outputs low
          next_count = {CW{1'b0}};
          next_dirUp = 1'b0;
          next_outA = 1'b0;
          next_outB = 1'b0;
        end else if (!upDown) begin
          next_dirUp = 1'b0;
          // Zero cycle reloads, so load pulse comes next cycle
          if (atZero) begin
            next_count = loadVal;
          end else begin
            next_count = count - 1'b1;
          end
        end else if (dirUp) begin
          if (count >= loadVal) begin
            next_dirUp = 1'b0;
            next_count = loadZero ? count : count - 1'b1;
          end else begin
            next_count = count + 1'b1;
          end
        end else begin
          if (atZero) begin
            next_dirUp = !loadZero;
            next_count = loadZero ? count : count + 1'b1;
          end else begin
            next_count = count - 1'b1;
          end
        end
      end

      always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          count <= {CW{1'b0}};
          dirUp <= 1'b0;
          outA <= 1'b0;
          outB <= 1'b0;
        end else begin
          count <= next_count;
          dirUp <= next_dirUp;
          outA <= next_outA;
          outB <= next_outB;
        end
      end

      assign firstGenOutput[g] = outA;
      assign secondGenOutput[g] = outB;
      // Unselected generators return zero so the read mux can simply OR
      assign rdVec[g] = selR ? readReg(rdRel, ctrl, loadVal, cmpA, cmpB, genA, genB,
                                       count, dirEff, outA, outB) : 32'h00000000;
    end
  endgenerate

  // Read data registered for the data phase from the address-phase address
  integer k;
  always @* begin
    next_rdData = 32'h00000000;
    for (k = 0; k < NGEN; k = k + 1) begin
      next_rdData = next_rdData | rdVec[k];
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData <= 32'h00000000;
    end else if (access && !hwrite) begin
      rdData <= next_rdData;
    end
  end

endmodule // pwg_core

// ---- include/pwg_defines.vh ----
`ifndef PWG_DEFINES_VH
`define PWG_DEFINES_VH

// Register byte offsets
`define PWG_OFF_CTRL 8'h00
`define PWG_OFF_LOAD 8'h04
`define PWG_OFF_CMPA 8'h08
`define PWG_OFF_CMPB 8'h0C
`define PWG_OFF_GENA 8'h10
`define PWG_OFF_GENB 8'h14
`define PWG_OFF_STAT 8'h18
`define PWG_GEN_STRIDE 8'h20
`define PWG_NUM_GEN 3

// Control fields
`define PWG_CTRL_EN 0
`define PWG_CTRL_UPDN 1

// Bus address and status fields
`define PWG_ADDR_BYTE 7:0
`define PWG_STAT_DIR 16
`define PWG_STAT_OUTA 17
`define PWG_STAT_OUTB 18

// Action field positions within a GEN register
`define PWG_ACT_ZERO 1:0
`define PWG_ACT_LOAD 3:2
`define PWG_ACT_AUP 5:4
`define PWG_ACT_ADN 7:6
`define PWG_ACT_BUP 9:8
`define PWG_ACT_BDN 11:10

// Action codes
`define PWG_NOP 2'h0
`define PWG_TOG 2'h1
`define PWG_LOW 2'h2
`define PWG_HIGH 2'h3

`define PWG_HTRANS_NONSEQ 2'h2
`define PWG_HTRANS_SEQ 2'h3

`endif

// ---- verification/pwg_core_props.sv ----
`timescale 1ns/100ps
module pwg_core_props (
  input wire clk, // Clock
  input wire sys_rst, // Reset
  input wire hsel, // Bus
  input wire [31:0] haddr, // Bus
  input wire [1:0] htrans, // Bus
  input wire hwrite, // Bus
  input wire [31:0] hwdata, // Bus
  input wire hready, // Bus
  input wire [31:0] hrdata, // Bus
  input wire hreadyout, // Bus
  input wire hresp, // Bus
  input wire [2:0] firstGenOutput, // Pins
  input wire [2:0] secondGenOutput // Pins
);
  reg wp;
  reg [7:0] wa;
  reg [1:0] ctl;
  reg [15:0] ld;
  wire ap = hsel && hready && htrans[1];
  // Shadow of generator 0 set-up, rebuilt from bus traffic alone
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp <= 1'b0;
      wa <= 8'h00;
      ctl <= 2'h0;
      ld <= 16'h0000;
    end else begin
      wp <= ap && hwrite;
      wa <= haddr[7:0];
      if (wp && wa == 8'h00) ctl <= hwdata[1:0];
      if (wp && wa == 8'h04) ld <= hwdata[15:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence rdStat; ap && !hwrite && haddr[7:0] == 8'h18; endsequence
  sequence offWr; ap && hwrite && haddr[7:0] == 8'h00 ##1 !hwdata[0]; endsequence
  AST_BUS: assert property (hreadyout && !hresp) else $error("bus answer wrong");
  AST_RST: assert property (disable iff (1'b0) sys_rst |-> !firstGenOutput)
    else $error("output high in reset");
  AST_OFF: assert property (offWr |=> ##1 (!firstGenOutput[0] && !secondGenOutput[0]) [*3])
    else $error("disabled outputs not low");
  AST_DIR: assert property (rdStat ##0 ctl == 2'h1 |=> !hrdata[16])
    else $error("direction high in down mode");
  AST_CNT: assert property (rdStat ##0 ctl[0] |=> hrdata[15:0] <= ld)
    else $error("count above load");
  AST_IDLE: assert property (rdStat ##0 (!ctl[0] && !$past(ctl[0])) |=> hrdata[18:0] == 19'h0)
    else $error("stopped status not clear");
  AST_PINS: assert property (rdStat |=> hrdata[17] == $past(firstGenOutput[0]))
    else $error("status pin bit wrong");
  AST_TOP: assert property (rdStat |=> hrdata[31:19] == 13'h0) else $error("status top set");
endmodule // pwg_core_props

bind pwg_core pwg_core_props u_props (.*);

// ---- verification/pwg_core_test.sv ----
`timescale 1ns/100ps
module pwg_core_test;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg hsel = 1'b0;
  reg hwrite = 1'b0;
  reg rdData = 1'b0;
  reg [1:0] htrans = 2'h0;
  reg [31:0] haddr = 32'h0, hwdata = 32'h0, m;
  reg [31:0] expV [$], expM [$];
  reg [15:0] ld, cA;
  wire [31:0] hrdata;
  wire hreadyout, hresp;
  wire [2:0] oa, ob;
  wire [15:0] hiLen [0:5], per [0:5];
  integer n_errors = 0, n_compared = 0, i;
  initial forever #5 clk = ~clk;
  pwg_core uut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .firstGenOutput(oa), .secondGenOutput(ob));
  pwg_gate_model gm (.clk(clk), .sys_rst(sys_rst), .gate({ob, oa}), .hiLen(hiLen), .per(per));
  task chk(input string nm, input [31:0] e, input [31:0] s);
    n_compared = n_compared + 1;
    if (s !== e) begin
      n_errors = n_errors + 1;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task xfer(input [31:0] a, input w, input [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
  endtask
  task rd(input [31:0] a, input [31:0] e, input [31:0] msk);
    expV.push_back(e);
    expM.push_back(msk);
    xfer(a, 1'b0, 32'h0);
  endtask
  task cfg(input [31:0] b, c, l, ca, cb, ga, gb);
    xfer(b + 4, 1'b1, l);
    xfer(b + 8, 1'b1, ca);
    xfer(b + 12, 1'b1, cb);
    xfer(b + 16, 1'b1, ga);
    xfer(b + 20, 1'b1, gb);
    xfer(b, 1'b1, c);
  endtask
  always @(posedge clk) rdData <= hsel && htrans[1] && !hwrite;
  // Mid-cycle sampling keeps clear of hrdata updating for a following read
  always @(negedge clk) begin
    if (rdData) begin
      m = expM.pop_front();
      chk("hrdata", expV.pop_front() & m, hrdata & m);
    end
  end
  initial begin
    i = $urandom(32'h8F53);
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 96; i = i + 4) rd(i, 32'h0, 32'hFFFFFFFF);
    chk("outputs", 32'h0, {26'h0, ob, oa});
    $display("T1 reset values done");
    ld = 16'd8 + 16'($urandom % 16);
    cA = 16'd1 + 16'($urandom % (ld - 16'd2));
    // B match equals A match on generator 1 so both fire together
    cfg(32'h00, 32'h1, {16'h0, ld}, 32'h0, 32'h0, 32'h00B, 32'h001);
    cfg(32'h20, 32'h3, {16'h0, ld}, {16'h0, cA}, {16'h0, cA}, 32'h0B0, 32'hB00);
    cfg(32'h40, 32'h1, {16'h0, ld}, 32'h0, {16'h0, ld + 16'd1}, 32'h0C0, 32'hC00);
    rd(32'h24, {16'h0, ld}, 32'hFFFFFFFF);
    rd(32'h30, 32'h0B0, 32'hFFFFFFFF);
    rd(32'h54, 32'hC00, 32'hFFFFFFFF);
    repeat (8 * ld + 40) @(posedge clk);
    rd(32'h18, 32'h0, 32'hFFF90000);
    @(negedge clk);
    chk("gen0 A high", 32'd1, {16'h0, hiLen[0]});
    chk("gen0 period", ld + 32'd1, {16'h0, per[0]});
    chk("gen0 B high", ld + 32'd1, {16'h0, hiLen[3]});
    chk("gen0 B period", 2 * ld + 32'd2, {16'h0, per[3]});
    chk("gen1 A high", 2 * (ld - cA), {16'h0, hiLen[1]});
    chk("gen1 period", 2 * ld, {16'h0, per[1]});
    chk("gen1 B high", 2 * (ld - cA), {16'h0, hiLen[4]});
    chk("gen2 lines", 32'h0, {30'h0, oa[2], ob[2]});
    $display("T2 waveforms done");
    @(posedge clk);
    xfer(32'h00, 1'b1, 32'h0);
    repeat (2) @(posedge clk);
    rd(32'h18, 32'h0, 32'hFFFFFFFF);
    chk("gen0 off", 32'h0, {30'h0, oa[0], ob[0]});
    $display("T3 disable done");
    report_and_stop;
  end
  initial begin
    #50000;
    n_errors = n_errors + 1;
    report_and_stop;
  end
  task report_and_stop;
    $display("Compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
endmodule // pwg_core_test

// ---- verification/pwg_gate_model.sv ----
`timescale 1ns/100ps
module pwg_gate_model (
  input wire clk, // Clock
  input wire sys_rst, // Reset
  input wire [5:0] gate, // Second and first lines
  output reg [15:0] hiLen [0:5], // Last high width
  output reg [15:0] per [0:5] // Last rise to rise span
);
  reg [5:0] last;
  reg [15:0] age [0:5];
  integer i;
  // Driver inputs only see levels per clock, so widths are whole cycles
  always @(posedge clk) begin
    last <= gate;
    for (i = 0; i < 6; i = i + 1) begin
      if (sys_rst) begin
        age[i] <= 16'h0000;
        per[i] <= 16'h0000;
        hiLen[i] <= 16'h0000;
      end else begin
        age[i] <= age[i] + 16'h0001;
        if (gate[i] && !last[i]) begin
          per[i] <= age[i];
          age[i] <= 16'h0001;
        end
        if (!gate[i] && last[i]) hiLen[i] <= age[i];
      end
    end
  end
endmodule // pwg_gate_model
